// *** rtl/cond_flags_pkg.sv ***
// Package for the condition-flag register block.
// Assumes a single 100 MHz core clock and an APB register port.
package cond_flags_pkg;

  localparam int FIELD_COUNT = 8;
  localparam int FIELD_WIDTH = 4;
  localparam int FLAG_WIDTH  = 32;
  localparam int BIT_OFFSET  = 32;

  // APB byte addresses
  localparam logic [11:0] ADDR_FLAGS  = 12'h000;
  localparam logic [11:0] ADDR_UPDATE = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // Bit positions within a field
  localparam int POS_LESS = 3;
  localparam int POS_GRTR = 2;
  localparam int POS_ZERO = 1;
  localparam int POS_OVFL = 0;

  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [3:0]  FIELD_NEG   = 4'h8;
  localparam logic [3:0]  FIELD_POS   = 4'h4;
  localparam logic [3:0]  FIELD_ZER   = 4'h2;

  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_MOVE    = 3'b001,
    OP_COPY    = 3'b010,
    OP_EXCREG  = 3'b011,
    OP_RECORD  = 3'b100,
    OP_ICMP    = 3'b101,
    OP_VCMP    = 3'b110,
    OP_LOGIC   = 3'b111
  } flag_op_t;

  typedef enum logic [1:0] {
    LG_AND = 2'b00,
    LG_OR  = 2'b01,
    LG_XOR = 2'b10,
    LG_NOR = 2'b11
  } logic_op_t;

  typedef struct packed {
    logic        valid;
    flag_op_t    op;
    logic [7:0]  field_mask;
    logic [2:0]  dst_field;
    logic [2:0]  src_field;
    logic [31:0] source;
    logic        double_word;
    logic        cmp_signed;
    logic        summary_ovf;
    logic [3:0]  exc_field;
    logic        vec_hi_eq;
    logic        vec_lo_eq;
    logic [4:0]  sel_a;
    logic [4:0]  sel_b;
    logic [4:0]  sel_d;
    logic_op_t   lop;
  } flag_req_t;

  typedef struct packed {
    logic [31:0] flags;
    logic        test_bit;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  update_count;
    logic        soft_write_en;
  } flag_state_t;

endpackage

// *** rtl/condition_flag_register.sv ***
// Condition-flag register: eight 4-bit fields with per-field updates.
// Assumes execution logic presents one update per cycle on req_in and an
// APB master on the core clock; core reset is a plain input.
//
// The APB slave port and the register addresses were left to the implementer.
module condition_flag_register
  import cond_flags_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     arst_n_in,
  input  wire logic                     clk_en_in,
  input  wire logic                     core_reset_n_in,
  // Execution update port
  input  wire cond_flags_pkg::flag_req_t req_in,
  input  wire logic [31:0]              cmp_operand_b_in,
  // Flag outputs
  output logic [31:0]                   flags_out,
  output logic                          test_bit_out,
  // APB slave
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [11:0]              paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic [31:0]                   prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out
);
  import cond_flags_pkg::*;

  // Refuse a field layout that does not fill the flag word
  if (FIELD_COUNT * FIELD_WIDTH != FLAG_WIDTH) begin : g_layout_check
    $error("field layout does not fill the flag word");
  end

  flag_state_t state;
  flag_state_t next_state;

  // Flag word index for a 5-bit selector: selector 0 picks bit 31, the MSB of the word
  function automatic logic pick_bit(input logic [31:0] f,
                                    input logic [4:0] sel);
    pick_bit = f[5'd31 - sel];
  endfunction

  // eight field layout
  // Field zero is bits 31:28 of the word
  function automatic logic [3:0] get_field(input logic [31:0] f,
                                           input logic [2:0] n);
    get_field = f[(3'd7 - n) * 4 +: 4];
  endfunction

  function automatic logic [3:0] record_field(input logic [31:0] r,
                                              input logic ovf);
    logic [3:0] c;
    c = 4'h0;
    if (r[31]) begin
      c = FIELD_NEG;
    end else if (r[30:0] != 31'h0) begin
      c = FIELD_POS;
    end else begin
      c = FIELD_ZER;
    end
    c[POS_OVFL] = ovf;
    record_field = c;
  endfunction

  logic [3:0]  new_field;
  logic        do_field;
  logic        a_bit;
  logic        b_bit;
  logic        l_bit;
  logic        less;
  logic        grtr;
  logic        apb_access;

  always_comb begin
    next_state = state;
    new_field  = 4'h0;
    do_field   = 1'b0;
    a_bit      = pick_bit(state.flags, req_in.sel_a);
    b_bit      = pick_bit(state.flags, req_in.sel_b);
    l_bit      = 1'b0;
    less       = 1'b0;
    grtr       = 1'b0;
    apb_access = psel_in && penable_in;
    next_state.pready  = 1'b0;
    next_state.pslverr = 1'b0;
    if (core_reset_n_in && req_in.valid) begin
      unique case (req_in.op)
        OP_NONE: begin
        end
        OP_MOVE: begin
          for (int i = 0; i < FIELD_COUNT; i++) begin
            if (req_in.field_mask[7 - i]) begin
              next_state.flags[(7 - i) * 4 +: 4] =
                req_in.source[(7 - i) * 4 +: 4];
            end
          end
        end
        OP_COPY: begin
          new_field = get_field(state.flags, req_in.src_field);
          do_field  = 1'b1;
        end
        OP_EXCREG: begin
          new_field = req_in.exc_field;
          do_field  = 1'b1;
        end
        OP_RECORD: begin
          if (!req_in.double_word) begin
            next_state.flags[31:28] =
              record_field(req_in.source, req_in.summary_ovf);
          end
        end
        OP_ICMP: begin
          if (req_in.cmp_signed) begin
            less = $signed(req_in.source) < $signed(cmp_operand_b_in);
            grtr = $signed(req_in.source) > $signed(cmp_operand_b_in);
          end else begin
            less = req_in.source < cmp_operand_b_in;
            grtr = req_in.source > cmp_operand_b_in;
          end
          new_field = {less, grtr, !(less || grtr), req_in.summary_ovf};
          do_field  = 1'b1;
        end
        OP_VCMP: begin
          new_field = {req_in.vec_hi_eq, req_in.vec_lo_eq,
                       req_in.vec_hi_eq | req_in.vec_lo_eq,
                       req_in.vec_hi_eq & req_in.vec_lo_eq};
          do_field  = 1'b1;
        end
        OP_LOGIC: begin
          unique case (req_in.lop)
            LG_AND: l_bit = a_bit & b_bit;
            LG_OR:  l_bit = a_bit | b_bit;
            LG_XOR: l_bit = a_bit ^ b_bit;
            LG_NOR: l_bit = !(a_bit | b_bit);
          endcase
          next_state.flags[5'd31 - req_in.sel_d] = l_bit;
        end
      endcase
      if (do_field) begin
        next_state.flags[(3'd7 - req_in.dst_field) * 4 +: 4] = new_field;
      end
      next_state.update_count = state.update_count + 8'h01;
    end
    next_state.test_bit = a_bit;
    // APB: one wait state; answer registered from the first access edge
    if (apb_access && !state.pready) begin
      next_state.pready = 1'b1;
      unique case (paddr_in)
        ADDR_FLAGS: begin
          next_state.prdata = state.flags;
        end
        ADDR_UPDATE: begin
          next_state.prdata = {31'h0, state.soft_write_en};
        end
        ADDR_STATUS: begin
          next_state.prdata = {24'h0, state.update_count};
        end
        default: begin
          next_state.prdata  = 32'h0;
          next_state.pslverr = 1'b1;
        end
      endcase
    end
    // Writes land on the edge that sees pready high; execution wins
    if (apb_access && state.pready && pwrite_in) begin
      if (paddr_in == ADDR_FLAGS && state.soft_write_en &&
          !(core_reset_n_in && req_in.valid)) begin
        next_state.flags = pwdata_in;
      end
      if (paddr_in == ADDR_UPDATE) begin
        next_state.soft_write_en = pwdata_in[0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= '{flags: FLAGS_RESET, test_bit: 1'b0, prdata: 32'h0,
                 pready: 1'b0, pslverr: 1'b0, update_count: 8'h00,
                 soft_write_en: 1'b1};
    end else if (clk_en_in) begin
      state <= next_state;
    end
  end

  assign flags_out    = state.flags;
  assign test_bit_out = state.test_bit;
  assign prdata_out   = state.prdata;
  assign pready_out   = state.pready;
  assign pslverr_out  = state.pslverr;

  a_core_reset_hold: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (!core_reset_n_in && clk_en_in && !(psel_in && penable_in))
      |=> $stable(flags_out))
    else $error("flags changed during core reset");

  a_record_negative: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_RECORD && !req_in.double_word && req_in.source[31])
      |=> flags_out[31:29] == 3'b100)
    else $error("negative result not recorded");

  a_record_zero: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_RECORD && !req_in.double_word &&
     req_in.source == 32'h0)
      |=> flags_out[31:29] == 3'b001)
    else $error("zero result not recorded");

  a_record_positive: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_RECORD && !req_in.double_word &&
     !req_in.source[31] && req_in.source[30:0] != 31'h0)
      |=> flags_out[31:29] == 3'b010)
    else $error("positive result not recorded");

  a_record_overflow: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_RECORD && !req_in.double_word)
      |=> flags_out[28] == $past(req_in.summary_ovf))
    else $error("overflow bit not copied");

  a_double_word_skip: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && req_in.valid && req_in.op == OP_RECORD &&
     req_in.double_word && !(psel_in && penable_in))
      |=> $stable(flags_out))
    else $error("double word changed flags");

  a_move_untouched: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_MOVE && req_in.field_mask[7] == 1'b0)
      |=> flags_out[31:28] == $past(flags_out[31:28]))
    else $error("unselected field zero changed");

  a_vector_compare: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_VCMP && req_in.dst_field == 3'd1 &&
     req_in.vec_hi_eq && !req_in.vec_lo_eq)
      |=> flags_out[27:24] == 4'hA)
    else $error("vector compare field wrong");

  a_apb_ready: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && psel_in && penable_in && !pready_out)
      |=> pready_out)
    else $error("apb access not answered");

  a_exception_load: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_EXCREG && req_in.dst_field == 3'd0)
      |=> flags_out[31:28] == $past(req_in.exc_field))
    else $error("exception field not loaded");

  a_field_copy: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_COPY && req_in.dst_field == 3'd7)
      |=> flags_out[3:0] == $past(flags_out[(3'd7 - req_in.src_field) * 4 +: 4]))
    else $error("field copy wrong");

  a_compare_equal: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid && req_in.op == OP_ICMP &&
     req_in.dst_field == 3'd2 && req_in.source == cmp_operand_b_in)
      |=> flags_out[23:21] == 3'b001)
    else $error("equal compare wrong");

  a_compare_overflow: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_ICMP && req_in.dst_field == 3'd3)
      |=> flags_out[16] == $past(req_in.summary_ovf))
    else $error("compare overflow bit wrong");

  a_unsigned_less: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid && req_in.op == OP_ICMP &&
     req_in.dst_field == 3'd4 && !req_in.cmp_signed &&
     req_in.source < cmp_operand_b_in)
      |=> flags_out[15:13] == 3'b100)
    else $error("unsigned less compare wrong");

  a_signed_less: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid && req_in.op == OP_ICMP &&
     req_in.dst_field == 3'd5 && req_in.cmp_signed &&
     $signed(req_in.source) < $signed(cmp_operand_b_in))
      |=> flags_out[11:9] == 3'b100)
    else $error("signed less compare wrong");

  a_compare_greater: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid && req_in.op == OP_ICMP &&
     req_in.dst_field == 3'd6 && !req_in.cmp_signed &&
     req_in.source > cmp_operand_b_in)
      |=> flags_out[7:5] == 3'b010)
    else $error("greater compare wrong");

  a_logic_and: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_LOGIC && req_in.lop == LG_AND)
      |=> flags_out[5'd31 - $past(req_in.sel_d)] ==
          $past(flags_out[5'd31 - req_in.sel_a] &
                flags_out[5'd31 - req_in.sel_b]))
    else $error("flag bit and wrong");

  a_logic_nor: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_LOGIC && req_in.lop == LG_NOR)
      |=> flags_out[5'd31 - $past(req_in.sel_d)] ==
          $past(!(flags_out[5'd31 - req_in.sel_a] |
                  flags_out[5'd31 - req_in.sel_b])))
    else $error("flag bit nor wrong");

  a_test_bit: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    clk_en_in
      |=> test_bit_out == $past(flags_out[5'd31 - req_in.sel_a]))
    else $error("tested flag bit wrong");

  a_move_written: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_MOVE && req_in.field_mask[0])
      |=> flags_out[3:0] == $past(req_in.source[3:0]))
    else $error("selected field seven not moved");

  a_vector_low: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_VCMP && req_in.dst_field == 3'd0 &&
     !req_in.vec_hi_eq && req_in.vec_lo_eq)
      |=> flags_out[31:28] == 4'h6)
    else $error("vector low compare wrong");

  a_record_others: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && core_reset_n_in && req_in.valid &&
     req_in.op == OP_RECORD && !req_in.double_word)
      |=> flags_out[27:0] == $past(flags_out[27:0]))
    else $error("record touched other fields");

endmodule

// *** verification/exec_unit_model.sv ***
// Model of the core execution units that feed flag updates.
// Assumes the bench calls issue once per cycle from its main thread.
module exec_unit_model
  import cond_flags_pkg::*;
(
  // Clock
  input  wire logic             clk_in,
  // Update port
  output cond_flags_pkg::flag_req_t req_out,
  output logic [31:0]           cmp_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_out   = '0;
    cmp_b_out = 32'h0000_0000;
  end
  // Presents one request just after a rising edge
  task automatic issue(input flag_req_t r, input logic [31:0] b);
    @(posedge clk_in);
    req_out   <= r;
    cmp_b_out <= b;
  endtask
endmodule

// *** verification/condition_flag_register_tb.sv ***
// Self-checking bench for the condition-flag register.
// Assumes the execution model and the APB tasks below are the only drivers.
module condition_flag_register_tb
  import cond_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, arst_n, en, crst_n, tbit, psel, pen, pwr;
  logic        pready, pslverr, err, e, c, t_ok, t_exp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, flags, bv, exp, rd;
  logic [95:0] raw;
  flag_req_t   req, r;
  int          mismatches, checks, cycles, upd;

  exec_unit_model u (.clk_in(clk), .req_out(req), .cmp_b_out(bv));
  condition_flag_register dut (
    .clk_in(clk), .arst_n_in(arst_n), .clk_en_in(en),
    .core_reset_n_in(crst_n), .req_in(req), .cmp_operand_b_in(bv),
    .flags_out(flags), .test_bit_out(tbit), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr));

  function automatic logic [31:0] predict(logic [31:0] f, flag_req_t q,
                                          logic [31:0] b);
    logic [31:0] n;
    logic        x, y, lt, gt;
    n  = f;
    lt = q.cmp_signed ? $signed(q.source) < $signed(b) : q.source < b;
    gt = q.cmp_signed ? $signed(q.source) > $signed(b) : q.source > b;
    x  = f[31-q.sel_a];
    y  = f[31-q.sel_b];
    case (q.op)
      OP_MOVE: for (int i = 0; i < 8; i++) if (q.field_mask[7-i])
        n[(7-i)*4+:4] = q.source[(7-i)*4+:4];
      OP_COPY: n[(7-q.dst_field)*4+:4] = f[(7-q.src_field)*4+:4];
      OP_EXCREG: n[(7-q.dst_field)*4+:4] = q.exc_field;
      OP_RECORD: if (!q.double_word) n[31:28] = {q.source[31],
        !q.source[31] && |q.source[30:0], q.source == 0, q.summary_ovf};
      OP_ICMP: n[(7-q.dst_field)*4+:4] = {lt, gt, q.source == b,
                                          q.summary_ovf};
      OP_VCMP: n[(7-q.dst_field)*4+:4] = {q.vec_hi_eq, q.vec_lo_eq,
        q.vec_hi_eq | q.vec_lo_eq, q.vec_hi_eq & q.vec_lo_eq};
      OP_LOGIC: case (q.lop)
        LG_AND:  n[31-q.sel_d] = x & y;
        LG_OR:   n[31-q.sel_d] = x | y;
        LG_XOR:  n[31-q.sel_d] = x ^ y;
        default: n[31-q.sel_d] = ~(x | y);
      endcase
      default: n = f;
    endcase
    return n;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, xv);
    checks++;
    if (seen !== xv) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, xv, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    arst_n = 1'b0;
    en     = 1'b1;
    crst_n = 1'b1;
    {psel, pen, pwr, paddr, pwdata} = '0;
    void'($urandom(24));
    exp  = FLAGS_RESET;
    t_ok = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    check("flags_reset", flags, exp);
    apb(1'b0, ADDR_UPDATE, 32'h0000_0000);
    check("enable_reset", rd, 32'h0000_0001);
    repeat (3000) begin
      raw = {$urandom, $urandom, $urandom};
      r   = raw[75:0];
      if ($urandom % 4 == 0) r.source = 32'h0000_0000;
      e = ($urandom % 8 != 0);
      c = ($urandom % 8 != 0);
      u.issue(r, ($urandom % 4 == 0) ? r.source : $urandom);
      en     <= e;
      crst_n <= c;
      @(negedge clk);
      check("flags", flags, exp);
      if (t_ok) check("test_bit", 32'(tbit), 32'(t_exp));
      t_exp = exp[31-r.sel_a];
      t_ok  = e;
      if (e && c && r.valid) begin
        exp = predict(exp, r, u.cmp_b_out);
        upd++;
      end
    end
    u.issue('0, 32'h0000_0000);
    en     <= 1'b1;
    crst_n <= 1'b1;
    @(negedge clk);
    check("flags_last", flags, exp);
    apb(1'b1, ADDR_FLAGS, 32'hA5C3_3C5A);
    apb(1'b0, ADDR_FLAGS, 32'h0000_0000);
    check("flags_rd", rd, 32'hA5C3_3C5A);
    check("flags_rd_err", 32'(err), 32'h0000_0000);
    apb(1'b1, ADDR_UPDATE, 32'h0000_0000);
    apb(1'b1, ADDR_FLAGS, 32'h1234_5678);
    @(negedge clk);
    check("flags_lock", flags, 32'hA5C3_3C5A);
    apb(1'b1, ADDR_UPDATE, 32'h0000_0001);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check("unmapped_err", 32'(err), 32'h0000_0001);
    check("unmapped_rd", rd, 32'h0000_0000);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    check("update_count", rd, 32'(upd % 256));
    end_sim();
  end
endmodule
